// File: verilog/hvioc_pkg.sv
// constants, register map and field layout of the high-voltage io config control block
//
// Overview of operation
// - temp monitor enable routes hv temperature monitor to voltage adc; clear powers it down
// - bit 5 shorts voltage channel at attenuator for noise self-test; clear removes short
// - bit 4 turns on wake/serial-test receivers and stops serial-test drive (wake drive unaffected); any edge raises hv interrupt
// - with readback on, monitor bit 7 shows wake pin, bit 5 serial-test pin
// - short counts after 20 us (lin, serial-test) or 400 us (wake); bit 3 re-enables
// - after thermal shutdown, writing re-enable restores wake and serial-test drivers
// - writing re-enable clears pending short-circuit interrupt only once short ended; a persisting short sets it again
// - re-enable bit clears itself after a write of one
// - bit 2 set: lin short raises interrupt and status, driver stays on
// - bit 2 clear: lin short raises interrupt, status, disables driver until re-enable
// - bit 1 clear: wake pin deasserted 1.3 s after assertion; set: no timeout
// - bit 0 switches diagnostic pull-up from wake pin to supply
// - registers reached only through command and data interface, not memory mapped
// - config zero bit 4 drives wake pin high; timeout measured from there
package hvioc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SHORT_FAST_US = 20;
    localparam int unsigned SHORT_WAKE_US = 400;
    localparam int unsigned WAKE_TIMEOUT_MS = 1300;
    localparam int unsigned SHORT_FAST_CYC = SHORT_FAST_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SHORT_WAKE_CYC = SHORT_WAKE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------
    // indirect register select codes
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_CFG0 = 2'h0;
    localparam logic [1:0] SEL_CFG1 = 2'h1;
    localparam logic [1:0] SEL_MON = 2'h2;
    localparam logic [1:0] SEL_STA = 2'h3;

    localparam logic [7:0] CFG0_RST = 8'h00;
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [4:0] STA_RST = 5'h00;
    // writable bits of hv_config_one (bit 7 not implemented, bit 3 self-clearing)
    localparam logic [7:0] CFG1_STORE_MASK = 8'h77;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG0_WAKE_ASSERT = 4;
    localparam int CFG1_TEMP_MON = 6;
    localparam int CFG1_VSHORT = 5;
    localparam int CFG1_READBACK = 4;
    localparam int CFG1_REENABLE = 3;
    localparam int CFG1_PASSIVE = 2;
    localparam int CFG1_TIMEOUT_DIS = 1;
    localparam int CFG1_PULLUP = 0;
    localparam int MON_WAKE_PIN = 7;
    localparam int MON_THERMAL = 6;
    localparam int MON_STI_PIN = 5;
    localparam int MON_LIN_SC = 2;
    localparam int MON_STI_SC = 1;
    localparam int MON_WAKE_SC = 0;
    localparam int STA_PIN_EDGE = 4;
    localparam int STA_THERMAL = 3;
    localparam int STA_LIN_SC = 2;
    localparam int STA_STI_SC = 1;
    localparam int STA_WAKE_SC = 0;

    // short channels: 0 lin, 1 serial-test, 2 wake
    localparam int NUM_SHORT = 3;
    localparam int CH_LIN = 0;
    localparam int CH_STI = 1;
    localparam int CH_WAKE = 2;
endpackage

// File: verilog/hvioc_short_filter.sv
// overcurrent persistence filter: synchronises and times one short-circuit sense line
`timescale 1ns/10ps
`default_nettype none
module hvioc_short_filter #(
    parameter int unsigned LIMIT = 400
) (
    input wire logic clock,        // 20 MHz clock
    input wire logic rst_b,        // synchronous reset, active low
    input wire logic overcurrent,  // async sense from analog driver
    output logic short_det         // overcurrent persisted beyond LIMIT cycles
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    typedef struct packed {
        logic [1:0] sync;
        logic [CW-1:0] cnt;
        logic det;
    } hvioc_flt_s;

    hvioc_flt_s st_q;
    hvioc_flt_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.sync = {st_q.sync[0], overcurrent};
        st_d.det = 1'b0;
        if (!st_q.sync[1]) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == LIM) begin
            st_d.det = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign short_det = st_q.det;
endmodule
`default_nettype wire

// File: verilog/hvioc_wake_timer.sv
// wake pin monoflop: ends a wake assertion after a fixed time
`timescale 1ns/10ps
`default_nettype none
module hvioc_wake_timer #(
    parameter int unsigned LIMIT = 26_000_000
) (
    input wire logic clock,      // 20 MHz clock
    input wire logic rst_b,      // synchronous reset, active low
    input wire logic start,      // one-cycle pulse on a new assertion
    input wire logic hold,       // wake assert level from software
    input wire logic disable_t,  // timeout counter switched off
    output logic expired         // timeout reached, level
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic exp;
    } hvioc_tmr_s;

    hvioc_tmr_s st_q;
    hvioc_tmr_s st_d;

    always_comb begin
        st_d = st_q;
        if (!hold || disable_t || start) begin
            st_d.cnt = '0;
            st_d.exp = 1'b0;
        end else if (!st_q.exp) begin
            if (st_q.cnt == LAST) begin
                st_d.exp = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign expired = st_q.exp;
endmodule
`default_nettype wire

// File: verilog/hvioc_top.sv
// high-voltage io configuration control: indirect registers, drivers, protection
`timescale 1ns/10ps
`default_nettype none
module hvioc_top #(
    parameter int unsigned SHORT_FAST_CYCLES = hvioc_pkg::SHORT_FAST_CYC,
    parameter int unsigned SHORT_WAKE_CYCLES = hvioc_pkg::SHORT_WAKE_CYC,
    parameter int unsigned WAKE_TIMEOUT_CYCLES = hvioc_pkg::WAKE_TIMEOUT_CYC
) (
    input wire logic clock,              // 20 MHz clock
    input wire logic rst_b,              // synchronous reset, active low
    input wire logic cmd_strobe,         // command request pulse
    input wire logic cmd_write,          // 1 write, 0 read
    input wire logic [1:0] cmd_sel,      // indirect register select
    input wire logic [7:0] cmd_wdata,    // write data
    output logic [7:0] cmd_rdata,        // read data, registered
    output logic cmd_rvalid,             // read data valid pulse
    input wire logic irq_enable_mask,    // hv interrupt enable from controller
    output logic hv_irq_line,            // hv interrupt request level
    output logic temp_monitor_enable,    // power and route hv temp monitor
    output logic vchan_short_enable,     // internal voltage channel short
    output logic pin_input_enable,       // wake/serial-test input receivers on
    output logic wake_pullup_enable,     // wake diagnostic pull-up
    input wire logic lin_overcurrent,    // async lin driver overcurrent sense
    input wire logic sti_overcurrent,    // async serial-test overcurrent sense
    input wire logic wake_overcurrent,   // async wake overcurrent sense
    input wire logic thermal_shutdown,   // async thermal event level
    output logic lin_driver_enable,      // lin driver allowed
    input wire logic sti_tx_data,        // serial-test output data
    input wire logic wake_pin_in,        // wake pin level
    output logic wake_pin_out,           // wake pin drive value
    output logic wake_pin_oe_b,          // wake pin enable, low drives
    input wire logic sti_pin_in,         // serial-test pin level
    output logic sti_pin_out,            // serial-test pin drive value
    output logic sti_pin_oe_b            // serial-test enable, low drives
);
    import hvioc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cfg0;
        logic [7:0] cfg1;
        logic [4:0] sta;
        logic lin_en;
        logic sti_en;
        logic wake_en;
        logic [1:0] wake_sync;
        logic [1:0] sti_sync;
        logic [1:0] therm_sync;
        logic wake_prev;
        logic sti_prev;
        logic therm_prev;
        logic [7:0] rdata;
        logic rvalid;
    } hvioc_state_s;

    hvioc_state_s st_q;
    hvioc_state_s st_d;

    logic [NUM_SHORT-1:0] oc_in;
    logic [NUM_SHORT-1:0] short_det;
    logic wake_expired;
    logic wr_cfg0;
    logic wr_cfg1;
    logic reenable;
    logic wake_start;
    logic therm;
    logic edge_evt;
    logic therm_rise;
    logic [7:0] mon;
    logic [4:0] sta_set;
    logic [4:0] sta_clr;

    // ------------------------------------------------------------
    // short-circuit persistence filters
    // ------------------------------------------------------------
    assign oc_in = {wake_overcurrent, sti_overcurrent, lin_overcurrent};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SHORT; gi++) begin : g_short
            hvioc_short_filter #(
                .LIMIT(gi == CH_WAKE ? SHORT_WAKE_CYCLES : SHORT_FAST_CYCLES)
            ) u_filter (
                .clock(clock),
                .rst_b(rst_b),
                .overcurrent(oc_in[gi]),
                .short_det(short_det[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // wake timeout
    // ------------------------------------------------------------
    hvioc_wake_timer #(
        .LIMIT(WAKE_TIMEOUT_CYCLES)
    ) u_wake_timer (
        .clock(clock),
        .rst_b(rst_b),
        .start(wake_start),
        .hold(st_q.cfg0[CFG0_WAKE_ASSERT]),
        .disable_t(st_q.cfg1[CFG1_TIMEOUT_DIS]),
        .expired(wake_expired)
    );

    // ------------------------------------------------------------
    // command decode and events
    // ------------------------------------------------------------
    always_comb begin
        wr_cfg0 = cmd_strobe && cmd_write && (cmd_sel == SEL_CFG0);
        wr_cfg1 = cmd_strobe && cmd_write && (cmd_sel == SEL_CFG1);
        reenable = wr_cfg1 && cmd_wdata[CFG1_REENABLE];
        wake_start = wr_cfg0 && cmd_wdata[CFG0_WAKE_ASSERT]
            && !st_q.cfg0[CFG0_WAKE_ASSERT];
        therm = st_q.therm_sync[1];
        therm_rise = therm && !st_q.therm_prev;
        edge_evt = st_q.cfg1[CFG1_READBACK]
            && ((st_q.wake_sync[1] != st_q.wake_prev)
            || (st_q.sti_sync[1] != st_q.sti_prev));
        sta_set = '0;
        sta_set[STA_PIN_EDGE] = edge_evt;
        sta_set[STA_THERMAL] = therm_rise;
        sta_set[STA_LIN_SC] = short_det[CH_LIN];
        sta_set[STA_STI_SC] = short_det[CH_STI];
        sta_set[STA_WAKE_SC] = short_det[CH_WAKE];
        sta_clr = '0;
        if (cmd_strobe && !cmd_write && (cmd_sel == SEL_STA)) begin
            sta_clr[STA_PIN_EDGE] = 1'b1;
            sta_clr[STA_THERMAL] = 1'b1;
        end
        if (reenable) begin
            sta_clr[STA_LIN_SC] = 1'b1;
            sta_clr[STA_STI_SC] = 1'b1;
            sta_clr[STA_WAKE_SC] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // live monitor view
    // ------------------------------------------------------------
    always_comb begin
        mon = 8'h00;
        if (st_q.cfg1[CFG1_READBACK]) begin
            mon[MON_WAKE_PIN] = st_q.wake_sync[1];
            mon[MON_STI_PIN] = st_q.sti_sync[1];
        end
        mon[MON_THERMAL] = therm;
        mon[MON_LIN_SC] = st_q.sta[STA_LIN_SC];
        mon[MON_STI_SC] = st_q.sta[STA_STI_SC];
        mon[MON_WAKE_SC] = st_q.sta[STA_WAKE_SC];
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.wake_sync = {st_q.wake_sync[0], wake_pin_in};
        st_d.sti_sync = {st_q.sti_sync[0], sti_pin_in};
        st_d.therm_sync = {st_q.therm_sync[0], thermal_shutdown};
        st_d.wake_prev = st_q.wake_sync[1];
        st_d.sti_prev = st_q.sti_sync[1];
        st_d.therm_prev = therm;
        st_d.rvalid = 1'b0;

        if (wr_cfg0) begin
            st_d.cfg0 = cmd_wdata;
        end
        if (wr_cfg1) begin
            st_d.cfg1 = cmd_wdata & CFG1_STORE_MASK;
        end

        // set wins over clear
        st_d.sta = (st_q.sta & ~sta_clr) | sta_set;

        // driver re-enable first, shutdown events override
        if (reenable) begin
            st_d.lin_en = 1'b1;
            st_d.sti_en = 1'b1;
            st_d.wake_en = 1'b1;
        end
        if (short_det[CH_LIN] && !st_q.cfg1[CFG1_PASSIVE]) begin
            st_d.lin_en = 1'b0;
        end
        if (short_det[CH_STI]) begin
            st_d.sti_en = 1'b0;
        end
        if (short_det[CH_WAKE]) begin
            st_d.wake_en = 1'b0;
        end
        if (therm_rise) begin
            st_d.lin_en = 1'b0;
            st_d.sti_en = 1'b0;
            st_d.wake_en = 1'b0;
        end

        if (cmd_strobe && !cmd_write) begin
            st_d.rvalid = 1'b1;
            case (cmd_sel)
                SEL_CFG0: st_d.rdata = st_q.cfg0;
                SEL_CFG1: st_d.rdata = st_q.cfg1;
                SEL_MON: st_d.rdata = mon;
                SEL_STA: st_d.rdata = {3'h0, st_q.sta};
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_q.cfg0 <= CFG0_RST;
            st_q.cfg1 <= CFG1_RST;
            st_q.sta <= STA_RST;
            st_q.lin_en <= 1'b1;
            st_q.sti_en <= 1'b1;
            st_q.wake_en <= 1'b1;
            st_q.wake_sync <= 2'h0;
            st_q.sti_sync <= 2'h0;
            st_q.therm_sync <= 2'h0;
            st_q.wake_prev <= 1'b0;
            st_q.sti_prev <= 1'b0;
            st_q.therm_prev <= 1'b0;
            st_q.rdata <= 8'h00;
            st_q.rvalid <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cmd_rdata = st_q.rdata;
    assign cmd_rvalid = st_q.rvalid;
    assign hv_irq_line = irq_enable_mask && (st_q.sta != STA_RST);
    assign temp_monitor_enable = st_q.cfg1[CFG1_TEMP_MON];
    assign vchan_short_enable = st_q.cfg1[CFG1_VSHORT];
    assign pin_input_enable = st_q.cfg1[CFG1_READBACK];
    assign wake_pullup_enable = st_q.cfg1[CFG1_PULLUP];
    assign lin_driver_enable = st_q.lin_en;
    assign wake_pin_out = 1'b1;
    assign wake_pin_oe_b = !(st_q.wake_en && st_q.cfg0[CFG0_WAKE_ASSERT]
        && !wake_expired);
    assign sti_pin_out = sti_tx_data;
    assign sti_pin_oe_b = !(st_q.sti_en && !st_q.cfg1[CFG1_READBACK]);
endmodule
`default_nettype wire

// File: test/hvioc_props.sv
// assertion checker for the high-voltage io config control block
`timescale 1ns/10ps
`default_nettype none
module hvioc_props #(
    parameter int unsigned SHORT_FAST_CYCLES = 4,
    parameter int unsigned SHORT_WAKE_CYCLES = 8,
    parameter int unsigned WAKE_TIMEOUT_CYCLES = 20
) (
    input wire logic clock,              // clock
    input wire logic rst_b,              // sync reset
    input wire logic cmd_strobe,         // request
    input wire logic cmd_write,          // write flag
    input wire logic [1:0] cmd_sel,      // select
    input wire logic [7:0] cmd_wdata,    // write data
    input wire logic [7:0] cmd_rdata,    // read data
    input wire logic cmd_rvalid,         // read valid
    input wire logic irq_enable_mask,    // irq mask
    input wire logic hv_irq_line,        // irq
    input wire logic temp_monitor_enable, // temp monitor
    input wire logic vchan_short_enable, // channel short
    input wire logic pin_input_enable,   // pin inputs
    input wire logic wake_pullup_enable, // pull-up
    input wire logic lin_overcurrent,    // lin sense
    input wire logic thermal_shutdown,   // thermal sense
    input wire logic lin_driver_enable,  // lin driver
    input wire logic wake_pin_oe_b,      // wake enable
    input wire logic sti_pin_oe_b        // serial-test enable
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    logic cfg1_wr;
    logic [7:0] recent_q;
    logic tmo_dis_q;
    int unsigned low_cnt_q;
    assign cfg1_wr = cmd_strobe && cmd_write && (cmd_sel == 2'h1);
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            recent_q <= 8'h00;
            tmo_dis_q <= 1'b0;
            low_cnt_q <= 0;
        end else begin
            recent_q <= {recent_q[6:0], lin_overcurrent | thermal_shutdown};
            if (cfg1_wr) begin
                tmo_dis_q <= cmd_wdata[1];
            end
            low_cnt_q <= (wake_pin_oe_b || tmo_dis_q) ? 0 : low_cnt_q + 1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    temp_cfg_a: assert property (cfg1_wr |=> temp_monitor_enable == $past(cmd_wdata[6]))
        else $error("temp monitor enable wrong");
    vchan_cfg_a: assert property (cfg1_wr |=> vchan_short_enable == $past(cmd_wdata[5]))
        else $error("channel short enable wrong");
    pin_cfg_a: assert property (cfg1_wr |=> pin_input_enable == $past(cmd_wdata[4]))
        else $error("pin input enable wrong");
    pullup_cfg_a: assert property (cfg1_wr |=>
        wake_pullup_enable == $past(cmd_wdata[0])) else $error("pull-up enable wrong");
    sti_input_a: assert property (pin_input_enable |-> sti_pin_oe_b)
        else $error("serial-test driven while input");
    oneshot_read_a: assert property (cmd_strobe && !cmd_write && cmd_sel == 2'h1 |=>
        cmd_rdata[3] == 1'b0 && cmd_rdata[7] == 1'b0) else $error("one-shot bit read as one");
    read_pulse_a: assert property (cmd_strobe && !cmd_write |=> cmd_rvalid)
        else $error("read valid missing");
    lin_restore_a: assert property ($rose(lin_driver_enable) |->
        $past(cfg1_wr && cmd_wdata[3])) else $error("lin driver restored without re-enable");
    lin_drop_a: assert property ($fell(lin_driver_enable) |-> |recent_q)
        else $error("lin driver dropped without cause");
    irq_gate_a: assert property (irq_enable_mask && $fell(lin_driver_enable) |->
        hv_irq_line) else $error("lin shutdown without irq");
    wake_tmo_a: assert property (low_cnt_q <= WAKE_TIMEOUT_CYCLES + 2)
        else $error("wake pin held past timeout");
    cover property (cfg1_wr && cmd_wdata[3]);
    cover property ($fell(lin_driver_enable));
    cover property ($rose(wake_pin_oe_b) && !tmo_dis_q);
endmodule
bind hvioc_top hvioc_props #(.SHORT_FAST_CYCLES(SHORT_FAST_CYCLES),
    .SHORT_WAKE_CYCLES(SHORT_WAKE_CYCLES), .WAKE_TIMEOUT_CYCLES(WAKE_TIMEOUT_CYCLES))
    i_hvioc_props (.clock(clock), .rst_b(rst_b), .cmd_strobe(cmd_strobe),
    .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .irq_enable_mask(irq_enable_mask), .hv_irq_line(hv_irq_line),
    .temp_monitor_enable(temp_monitor_enable), .vchan_short_enable(vchan_short_enable),
    .pin_input_enable(pin_input_enable), .wake_pullup_enable(wake_pullup_enable),
    .lin_overcurrent(lin_overcurrent), .thermal_shutdown(thermal_shutdown),
    .lin_driver_enable(lin_driver_enable), .wake_pin_oe_b(wake_pin_oe_b),
    .sti_pin_oe_b(sti_pin_oe_b));
`default_nettype wire

// File: test/tb_hvioc_top.sv
// self-checking testbench for the high-voltage io config control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_hvioc_top;
    import hvioc_pkg::*;
    logic clock = 0, rst_b = 0, cmd_strobe = 0, cmd_write = 0, irq_enable_mask = 1;
    logic [1:0] cmd_sel = 0;
    logic [7:0] cmd_wdata = 0, cmd_rdata;
    logic lin_oc = 0, sti_oc = 0, wake_oc = 0, thermal = 0, sti_tx = 0, wake_in = 0, sti_in = 0;
    logic cmd_rvalid, hv_irq, temp_en, vsh_en, pin_en, pull_en, lin_en;
    logic wake_out, wake_oe_b, sti_out, sti_oe_b;
    int fail_count = 0, check_count = 0;
    hvioc_top #(.SHORT_FAST_CYCLES(4), .SHORT_WAKE_CYCLES(8), .WAKE_TIMEOUT_CYCLES(20))
        i_hvioc_top (
        .clock(clock), .rst_b(rst_b), .cmd_strobe(cmd_strobe), .cmd_write(cmd_write),
        .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .irq_enable_mask(irq_enable_mask), .hv_irq_line(hv_irq), .temp_monitor_enable(temp_en),
        .vchan_short_enable(vsh_en), .pin_input_enable(pin_en), .wake_pullup_enable(pull_en),
        .lin_overcurrent(lin_oc), .sti_overcurrent(sti_oc), .wake_overcurrent(wake_oc),
        .thermal_shutdown(thermal), .lin_driver_enable(lin_en), .sti_tx_data(sti_tx),
        .wake_pin_in(wake_in), .wake_pin_out(wake_out), .wake_pin_oe_b(wake_oe_b),
        .sti_pin_in(sti_in), .sti_pin_out(sti_out), .sti_pin_oe_b(sti_oe_b));
    initial begin
        forever #25 clock = ~clock;
    end
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge clock);
        cmd_strobe <= 1'b1;
        cmd_write <= 1'b1;
        cmd_sel <= sel;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_strobe <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [1:0] sel, input logic [7:0] e);
        @(posedge clock);
        cmd_strobe <= 1'b1;
        cmd_write <= 1'b0;
        cmd_sel <= sel;
        @(posedge clock);
        cmd_strobe <= 1'b0;
        #1;
        `CHK(cmd_rvalid, 1'b1)
        `CHK(cmd_rdata, e)
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_cfg;
        logic [7:0] d;
        logic [3:0] o;
        rd_chk(SEL_CFG1, 8'h00);
        wr(SEL_CFG1, 8'hFF);
        rd_chk(SEL_CFG1, 8'h77);
        for (int i = 0; i < 8; i++) begin
            d = 8'h01 << i;
            wr(SEL_CFG1, d);
            o = {temp_en, vsh_en, pin_en, pull_en};
            `CHK(o, {d[6], d[5], d[4], d[0]})
        end
        wr(SEL_CFG1, 8'h00);
        $display("test cfg done");
    endtask
    task automatic t_readback;
        wr(SEL_CFG1, 8'h10);
        `CHK(sti_oe_b, 1'b1)
        @(posedge clock);
        wake_in <= 1'b1;
        cyc(5);
        rd_chk(SEL_MON, 8'h80);
        irq_enable_mask <= 1'b0;
        cyc(1);
        `CHK(hv_irq, 1'b0)
        irq_enable_mask <= 1'b1;
        cyc(1);
        `CHK(hv_irq, 1'b1)
        rd_chk(SEL_STA, 8'h10);
        rd_chk(SEL_STA, 8'h00);
        wake_in <= 1'b0;
        sti_in <= 1'b1;
        cyc(5);
        rd_chk(SEL_MON, 8'h20);
        rd_chk(SEL_STA, 8'h10);
        wr(SEL_CFG1, 8'h00);
        sti_in <= 1'b0;
        cyc(5);
        rd_chk(SEL_MON, 8'h00);
        rd_chk(SEL_STA, 8'h00);
        $display("test readback done");
    endtask
    task automatic t_lin(input logic p);
        wr(SEL_CFG1, {5'h00, p, 2'h0});
        lin_oc <= 1'b1;
        cyc(3);
        lin_oc <= 1'b0;
        cyc(6);
        `CHK(lin_en, 1'b1)
        rd_chk(SEL_STA, 8'h00);
        lin_oc <= 1'b1;
        cyc(12);
        lin_oc <= 1'b0;
        cyc(4);
        `CHK(lin_en, p)
        `CHK(hv_irq, 1'b1)
        rd_chk(SEL_STA, 8'h04);
        rd_chk(SEL_STA, 8'h04);
        wr(SEL_CFG1, {5'h01, p, 2'h0});
        `CHK(lin_en, 1'b1)
        `CHK(hv_irq, 1'b0)
        rd_chk(SEL_CFG1, {5'h00, p, 2'h0});
        $display("test lin short done");
    endtask
    task automatic t_drv;
        wr(SEL_CFG1, 8'h02);
        wr(SEL_CFG0, 8'h10);
        `CHK({wake_oe_b, sti_oe_b}, 2'b00)
        rd_chk(SEL_CFG0, 8'h10);
        wake_oc <= 1'b1;
        sti_oc <= 1'b1;
        cyc(7);
        wake_oc <= 1'b0;
        sti_oc <= 1'b0;
        cyc(4);
        `CHK({wake_oe_b, sti_oe_b}, 2'b01)
        rd_chk(SEL_STA, 8'h02);
        wake_oc <= 1'b1;
        cyc(14);
        wake_oc <= 1'b0;
        cyc(4);
        `CHK(wake_oe_b, 1'b1)
        rd_chk(SEL_STA, 8'h03);
        wr(SEL_CFG1, 8'h0A);
        `CHK({wake_oe_b, sti_oe_b}, 2'b00)
        rd_chk(SEL_STA, 8'h00);
        thermal <= 1'b1;
        cyc(6);
        `CHK({wake_oe_b, sti_oe_b, lin_en}, 3'b110)
        rd_chk(SEL_MON, 8'h40);
        rd_chk(SEL_STA, 8'h08);
        cyc(10);
        `CHK({wake_oe_b, sti_oe_b}, 2'b11)
        wr(SEL_CFG1, 8'h0A);
        cyc(6);
        `CHK({wake_oe_b, sti_oe_b, lin_en}, 3'b001)
        thermal <= 1'b0;
        wr(SEL_CFG0, 8'h00);
        wr(SEL_CFG1, 8'h00);
        $display("test drivers done");
    endtask
    task automatic t_timeout;
        int n;
        wr(SEL_CFG0, 8'h10);
        n = 0;
        while (wake_oe_b === 1'b0 && n < 100) begin
            cyc(1);
            n++;
        end
        if (n >= 100) begin
            fail_count++;
            tally_and_finish();
        end
        `CHK(n inside {[18:22]}, 1'b1)
        wr(SEL_CFG0, 8'h00);
        wr(SEL_CFG0, 8'h10);
        cyc(10);
        wr(SEL_CFG0, 8'h00);
        `CHK(wake_oe_b, 1'b1)
        wr(SEL_CFG0, 8'h10);
        cyc(15);
        `CHK(wake_oe_b, 1'b0)
        cyc(10);
        `CHK(wake_oe_b, 1'b1)
        wr(SEL_CFG1, 8'h02);
        cyc(40);
        `CHK(wake_oe_b, 1'b0)
        wr(SEL_CFG0, 8'h00);
        $display("test timeout done");
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        rd_chk(SEL_STA, 8'h00);
        `CHK({lin_en, wake_oe_b, sti_oe_b}, 3'b110)
        sti_tx <= 1'b1;
        cyc(1);
        `CHK({wake_out, sti_out}, 2'b11)
        sti_tx <= 1'b0;
        t_cfg();
        t_readback();
        t_lin(1'b0);
        t_lin(1'b1);
        t_drv();
        t_timeout();
        tally_and_finish();
    end
endmodule
`default_nettype wire
